// File: include/trf_pkg.sv
// constants and types shared by the timer and relay function blocks
`default_nettype none
package trf_pkg;
  // clock and shared time base
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_TIME_NS  = 1_000_000;
  localparam int TICK_CYCLES   = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // preset width
  localparam int PRESET_W      = 16;
  // positions of the sampled input vector
  localparam int IN_OOD_TRG    = 0;
  localparam int IN_RTO_TRG    = 1;
  localparam int IN_RTO_CLR    = 2;
  localparam int IN_LAT_SET    = 3;
  localparam int IN_LAT_CLR    = 4;
  localparam int IN_TOG_TRG    = 5;
  localparam int IN_TOG_CLR    = 6;
  localparam int IN_PLS_TRG    = 7;
  localparam int IN_W          = 8;
  // reset values
  localparam logic Q_RESET     = 1'b0;
  localparam logic RET_RESET   = 1'b0;
  // on/off delay states
  typedef enum logic [3:0] {
    OOD_IDLE     = 4'h1,
    OOD_ON_WAIT  = 4'h2,
    OOD_ON       = 4'h4,
    OOD_OFF_WAIT = 4'h8
  } trf_ood_state_t;
endpackage
`default_nettype wire

// File: src/trf_timer.sv
// elapsed time counter that counts time base ticks up to a preset
`default_nettype none
module trf_timer #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // control
  input  wire logic         tick,
  input  wire logic         clr,
  input  wire logic         run,
  input  wire logic [W-1:0] preset,
  // status
  output logic      [W-1:0] elapsed,
  output logic              done
);
  logic [W-1:0] elapsed_reg;

  // saturates at the preset so done stays up while the owner decides
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      elapsed_reg <= '0;
    end else if (clr) begin
      elapsed_reg <= '0;
    end else if (run && tick && (elapsed_reg != preset)) begin
      elapsed_reg <= elapsed_reg + W'(1);
    end
  end

  assign elapsed = elapsed_reg;
  assign done    = (elapsed_reg == preset);
endmodule
`default_nettype wire

// File: src/trf_top.sv
// on/off delay, retentive on delay, latch, toggle relay and pulse relay blocks
`default_nettype none
module trf_top #(
  parameter int TICK_DIV = trf_pkg::TICK_CYCLES,
  parameter int PW       = trf_pkg::PRESET_W
) (
  // clock and resets
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          cold_rst,
  // on/off delay
  input  wire logic          ood_trg,
  input  wire logic [PW-1:0] ood_on_preset,
  input  wire logic [PW-1:0] ood_off_preset,
  output logic               ood_q,
  // retentive on delay
  input  wire logic          rto_trg,
  input  wire logic          rto_clr,
  input  wire logic [PW-1:0] rto_preset,
  output logic               rto_q,
  // latch cell
  input  wire logic          latch_cell_set,
  input  wire logic          latch_cell_clr,
  input  wire logic          latch_cell_retain,
  output logic               latch_cell_q,
  // toggle relay
  input  wire logic          tog_trg,
  input  wire logic          tog_clr,
  input  wire logic          tog_retain,
  output logic               tog_q,
  // pulse relay
  input  wire logic          pls_trg,
  input  wire logic [PW-1:0] pls_preset,
  output logic               pls_q
);
  localparam int DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

  logic [trf_pkg::IN_W-1:0] in_raw;
  logic [trf_pkg::IN_W-1:0] in_s_reg;
  logic [trf_pkg::IN_W-1:0] in_p_reg;
  logic [trf_pkg::IN_W-1:0] in_rise;
  logic                     live_reg;
  logic [DIV_W-1:0]         div_reg;
  logic                     tick_reg;
  trf_pkg::trf_ood_state_t  ood_state_reg;
  logic                     ood_q_reg;
  logic                     rto_run_reg;
  logic                     rto_q_reg;
  logic                     lat_q_reg;
  logic                     lat_ret_reg;
  logic                     tog_q_reg;
  logic                     tog_ret_reg;
  logic                     pls_run_reg;
  logic [PW-1:0]            on_el;
  logic [PW-1:0]            off_el;
  logic [PW-1:0]            rto_el;
  logic [PW-1:0]            pls_el;
  logic                     on_done;
  logic                     off_done;
  logic                     rto_done;
  logic                     pls_done;
  logic                     ood_trg_s;
  logic                     rto_clr_s;
  logic                     pls_trg_s;

  assign in_raw = {pls_trg, tog_clr, tog_trg, latch_cell_clr, latch_cell_set, rto_clr, rto_trg, ood_trg};

  // inputs are sampled once; edges compare the sample with the one before
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      in_s_reg <= '0;
      in_p_reg <= '0;
    end else begin
      in_s_reg <= in_raw;
      // restore cycle copies the raw sample: a level held through restore is no edge
      in_p_reg <= live_reg ? in_s_reg : in_raw;
    end
  end

  assign in_rise   = in_s_reg & ~in_p_reg;
  assign ood_trg_s = in_s_reg[trf_pkg::IN_OOD_TRG];
  assign rto_clr_s = in_s_reg[trf_pkg::IN_RTO_CLR];
  assign pls_trg_s = in_s_reg[trf_pkg::IN_PLS_TRG];

  // first cycle after power restoration is spent restoring retained state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      live_reg <= 1'b0;
    end else begin
      live_reg <= 1'b1;
    end
  end

  // shared time base
  // tick phase is set by reset, not by a trigger, so a delay may run up to one tick short
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == DIV_W'(TICK_DIV - 1)) begin
      div_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + DIV_W'(1);
      tick_reg <= 1'b0;
    end
  end

  // timers; rst clears every count, nothing of elapsed time survives
  trf_timer #(.W(PW)) u_on_tmr (
    .clk     (ref_clk),
    .rst     (rst),
    .tick    (tick_reg),
    .clr     (ood_state_reg != trf_pkg::OOD_ON_WAIT),
    .run     (ood_state_reg == trf_pkg::OOD_ON_WAIT),
    .preset  (ood_on_preset),
    .elapsed (on_el),
    .done    (on_done)
  );

  trf_timer #(.W(PW)) u_off_tmr (
    .clk     (ref_clk),
    .rst     (rst),
    .tick    (tick_reg),
    .clr     (ood_state_reg != trf_pkg::OOD_OFF_WAIT),
    .run     (ood_state_reg == trf_pkg::OOD_OFF_WAIT),
    .preset  (ood_off_preset),
    .elapsed (off_el),
    .done    (off_done)
  );

  trf_timer #(.W(PW)) u_rto_tmr (
    .clk     (ref_clk),
    .rst     (rst),
    .tick    (tick_reg),
    .clr     (rto_clr_s),
    .run     (rto_run_reg),
    .preset  (rto_preset),
    .elapsed (rto_el),
    .done    (rto_done)
  );

  trf_timer #(.W(PW)) u_pls_tmr (
    .clk     (ref_clk),
    .rst     (rst),
    .tick    (tick_reg),
    .clr     (!pls_run_reg),
    .run     (pls_run_reg),
    .preset  (pls_preset),
    .elapsed (pls_el),
    .done    (pls_done)
  );

  // on/off delay
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ood_state_reg <= trf_pkg::OOD_IDLE;
      ood_q_reg     <= trf_pkg::Q_RESET;
    end else if (live_reg) begin
      case (ood_state_reg)
        trf_pkg::OOD_IDLE: begin
          if (in_rise[trf_pkg::IN_OOD_TRG]) begin
            ood_state_reg <= trf_pkg::OOD_ON_WAIT;
          end
        end
        trf_pkg::OOD_ON_WAIT: begin
          if (!ood_trg_s) begin
            ood_state_reg <= trf_pkg::OOD_IDLE;
          end else if (on_done) begin
            ood_state_reg <= trf_pkg::OOD_ON;
            ood_q_reg     <= 1'b1;
          end
        end
        trf_pkg::OOD_ON: begin
          if (!ood_trg_s) begin
            ood_state_reg <= trf_pkg::OOD_OFF_WAIT;
          end
        end
        trf_pkg::OOD_OFF_WAIT: begin
          if (ood_trg_s) begin
            ood_state_reg <= trf_pkg::OOD_ON;
          end else if (off_done) begin
            ood_state_reg <= trf_pkg::OOD_IDLE;
            ood_q_reg     <= 1'b0;
          end
        end
        default: begin
          ood_state_reg <= trf_pkg::OOD_IDLE;
          ood_q_reg     <= trf_pkg::Q_RESET;
        end
      endcase
    end
  end

  // retentive on delay; clear wins over a trigger in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rto_run_reg <= 1'b0;
      rto_q_reg   <= trf_pkg::Q_RESET;
    end else if (rto_clr_s) begin
      rto_run_reg <= 1'b0;
      rto_q_reg   <= 1'b0;
    end else if (live_reg) begin
      if (in_rise[trf_pkg::IN_RTO_TRG]) begin
        rto_run_reg <= 1'b1;
      end
      if (rto_run_reg && rto_done) begin
        rto_q_reg <= 1'b1;
      end
    end
  end

  // latch cell
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lat_q_reg <= trf_pkg::Q_RESET;
    end else if (!live_reg) begin
      lat_q_reg <= latch_cell_retain ? lat_ret_reg : 1'b0;
    end else if (in_s_reg[trf_pkg::IN_LAT_CLR]) begin
      lat_q_reg <= 1'b0;
    end else if (in_s_reg[trf_pkg::IN_LAT_SET]) begin
      lat_q_reg <= 1'b1;
    end
  end

  // retained copies survive rst; only cold_rst (memory lost) clears them
  always_ff @(posedge ref_clk or posedge cold_rst) begin
    if (cold_rst) begin
      lat_ret_reg <= trf_pkg::RET_RESET;
      tog_ret_reg <= trf_pkg::RET_RESET;
    end else if (live_reg) begin
      lat_ret_reg <= lat_q_reg;
      tog_ret_reg <= tog_q_reg;
    end
  end

  // toggle relay
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tog_q_reg <= trf_pkg::Q_RESET;
    end else if (!live_reg) begin
      tog_q_reg <= tog_retain ? tog_ret_reg : 1'b0;
    end else if (in_s_reg[trf_pkg::IN_TOG_CLR]) begin
      tog_q_reg <= 1'b0;
    end else if (in_rise[trf_pkg::IN_TOG_TRG]) begin
      tog_q_reg <= !tog_q_reg;
    end
  end

  // pulse relay; output and run flag are the same flop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pls_run_reg <= 1'b0;
    end else if (!live_reg) begin
      pls_run_reg <= 1'b0;
    end else if (in_rise[trf_pkg::IN_PLS_TRG]) begin
      pls_run_reg <= 1'b1;
    end else if (!pls_trg_s) begin
      pls_run_reg <= 1'b0;
    end else if (pls_done) begin
      pls_run_reg <= 1'b0;
    end
  end

  assign ood_q        = ood_q_reg;
  assign rto_q        = rto_q_reg;
  assign latch_cell_q = lat_q_reg;
  assign tog_q        = tog_q_reg;
  assign pls_q        = pls_run_reg;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_ood_on_set: assert property (ood_state_reg == trf_pkg::OOD_ON_WAIT && on_done && ood_trg_s
      |=> ood_q_reg) else $error("on delay did not set output");
  a_ood_abort: assert property (ood_state_reg == trf_pkg::OOD_ON_WAIT && !ood_trg_s
      |=> !ood_q_reg ##1 (on_el == '0)) else $error("on delay abort not cleared");
  a_ood_off_clr: assert property (ood_state_reg == trf_pkg::OOD_OFF_WAIT && off_done && !ood_trg_s
      |=> !ood_q_reg) else $error("off delay did not clear output");
  a_ood_resume: assert property (ood_state_reg == trf_pkg::OOD_OFF_WAIT && ood_trg_s
      |=> ood_q_reg ##1 (off_el == '0)) else $error("off delay resume wrong");
  a_restore_zero: assert property (!live_reg
      |-> on_el == '0 && off_el == '0 && rto_el == '0) else $error("elapsed time survived restore");
  a_rto_set: assert property (rto_run_reg && rto_done && !rto_clr_s && live_reg
      |=> rto_q_reg) else $error("retentive delay did not set");
  a_rto_ignore: assert property (rto_run_reg && !rto_clr_s && !tick_reg
      |=> rto_run_reg && rto_el == $past(rto_el)) else $error("retentive time disturbed");
  a_rto_clear: assert property (rto_clr_s
      |=> !rto_q_reg && rto_el == '0 && !rto_run_reg) else $error("retentive clear failed");
  a_latch_table: assert property (live_reg && in_s_reg[trf_pkg::IN_LAT_CLR]
      |=> !lat_q_reg) else $error("latch clear did not dominate");
  a_latch_restore: assert property (!live_reg && latch_cell_retain
      |=> lat_q_reg == $past(lat_ret_reg)) else $error("latch not restored");
  a_tog_flip: assert property (live_reg && in_rise[trf_pkg::IN_TOG_TRG] && !in_s_reg[trf_pkg::IN_TOG_CLR]
      |=> tog_q_reg != $past(tog_q_reg)) else $error("toggle did not invert");
  a_tog_clear: assert property (live_reg && in_s_reg[trf_pkg::IN_TOG_CLR]
      |=> !tog_q_reg) else $error("toggle clear failed");
  a_tog_restore: assert property (!live_reg && !tog_retain
      |=> !tog_q_reg) else $error("toggle not cleared on restore");
  a_pls_start: assert property (live_reg && in_rise[trf_pkg::IN_PLS_TRG]
      |=> pls_run_reg && pls_el == '0) else $error("pulse did not start");
  a_pls_expire: assert property (live_reg && pls_run_reg && pls_done && !in_rise[trf_pkg::IN_PLS_TRG]
      |=> !pls_run_reg) else $error("pulse did not end at preset");
  a_pls_fall: assert property (pls_run_reg && !pls_trg_s
      |=> !pls_run_reg) else $error("pulse did not drop on fall");
  // restore edge, latch table and retentive hold
  a_edge_restore: assert property (!live_reg
      |=> in_rise == '0) else $error("false edge after restore");
  a_latch_set: assert property (live_reg && in_s_reg[trf_pkg::IN_LAT_SET] && !in_s_reg[trf_pkg::IN_LAT_CLR]
      |=> lat_q_reg) else $error("latch set failed");
  a_latch_hold: assert property (live_reg && !in_s_reg[trf_pkg::IN_LAT_SET] && !in_s_reg[trf_pkg::IN_LAT_CLR]
      |=> lat_q_reg == $past(lat_q_reg)) else $error("latch did not hold");
  a_rto_hold: assert property (rto_q_reg && !rto_clr_s
      |=> rto_q_reg) else $error("retentive output dropped without clear");

  c_ood_cycle: cover property (ood_state_reg == trf_pkg::OOD_OFF_WAIT && off_done && !ood_trg_s);
  c_rto_set: cover property (rto_run_reg && rto_done ##1 rto_q_reg);
  c_tog_two: cover property (tog_q_reg ##[1:20] !tog_q_reg);
  c_pls_expire: cover property (pls_run_reg && pls_done && pls_trg_s);
  c_latch_restore: cover property (!live_reg && latch_cell_retain ##1 lat_q_reg);
endmodule
`default_nettype wire

// File: dv/trf_prog_model.sv
// model of the surrounding program logic: static presets for the timed blocks
`default_nettype none
module trf_prog_model #(
  parameter int PW     = 16,
  parameter int ON_T   = 5,
  parameter int OFF_T  = 5,
  parameter int RTO_T  = 5,
  parameter int PLS_T  = 5
) (
  // static presets in time base ticks
  output logic [PW-1:0] ood_on_preset,
  output logic [PW-1:0] ood_off_preset,
  output logic [PW-1:0] rto_preset,
  output logic [PW-1:0] pls_preset
);
  timeunit 1ns;
  timeprecision 1ps;
  // held for the whole run; the blocks give no meaning to a mid-run change
  assign ood_on_preset  = PW'(ON_T);
  assign ood_off_preset = PW'(OFF_T);
  assign rto_preset     = PW'(RTO_T);
  assign pls_preset     = PW'(PLS_T);
endmodule
`default_nettype wire

// File: dv/timer_relay_functions_tb_top.sv
// bench for the timer and relay function blocks
`default_nettype none
module timer_relay_functions_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QO = 0;
  localparam int QR = 1;
  localparam int QL = 2;
  localparam int QT = 3;
  localparam int QP = 4;
  localparam logic [5:0] LS = 6'h0D;
  localparam logic [5:0] LC = 6'h14;
  localparam logic [5:0] LE = 6'h0B;
  logic                          ref_clk, rst, cold_rst, ood_trg, rto_trg, rto_clr, tog_trg, tog_clr, pls_trg;
  logic                          latch_cell_set, latch_cell_clr, latch_cell_retain, tog_retain;
  logic                          ood_q, rto_q, latch_cell_q, tog_q, pls_q;
  logic [trf_pkg::PRESET_W-1:0]  ood_on_preset, ood_off_preset, rto_preset, pls_preset;
  logic [4:0]                    q;
  int                            mismatches = 0;
  int                            tests_run = 0;
  assign q = {pls_q, tog_q, latch_cell_q, rto_q, ood_q};

  trf_prog_model #(.PW(trf_pkg::PRESET_W)) i_prog (.ood_on_preset, .ood_off_preset, .rto_preset, .pls_preset);
  trf_top #(.TICK_DIV(4), .PW(trf_pkg::PRESET_W)) i_dut (
    .ref_clk, .rst, .cold_rst, .ood_trg, .ood_on_preset, .ood_off_preset, .ood_q,
    .rto_trg, .rto_clr, .rto_preset, .rto_q, .latch_cell_set, .latch_cell_clr, .latch_cell_retain,
    .latch_cell_q, .tog_trg, .tog_clr, .tog_retain, .tog_q, .pls_trg, .pls_preset, .pls_q
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %b expected %b", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // bounded wait for output i to reach v, then compare
  task automatic wait_q(input int i, input logic v, input int n);
    int k;
    k = 0;
    while (q[i] !== v && k < n) begin
      cyc(1);
      k++;
    end
    check(q[i], v);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // preset 5 ticks of 4 cycles: 14 cycles never reach it, 28 would
  task automatic t_ood();
    ood_trg = 1'b1;
    cyc(14);
    ood_trg = 1'b0;
    cyc(2);
    ood_trg = 1'b1;
    cyc(14);
    check(q[QO], 1'b0);
    wait_q(QO, 1'b1, 12);
    ood_trg = 1'b0;
    cyc(14);
    ood_trg = 1'b1;
    cyc(2);
    ood_trg = 1'b0;
    cyc(14);
    check(q[QO], 1'b1);
    wait_q(QO, 1'b0, 12);
    $display("on/off delay test done");
  endtask

  // a restart on the second rise would land after cycle 24
  task automatic t_rto();
    rto_trg = 1'b1;
    cyc(4);
    rto_trg = 1'b0;
    cyc(4);
    rto_trg = 1'b1;
    cyc(3);
    rto_trg = 1'b0;
    cyc(3);
    check(q[QR], 1'b0);
    wait_q(QR, 1'b1, 10);
    cyc(40);
    check(q[QR], 1'b1);
    rto_clr = 1'b1;
    cyc(3);
    check(q[QR], 1'b0);
    rto_clr = 1'b0;
    cyc(30);
    check(q[QR], 1'b0);
    $display("retentive delay test done");
  endtask

  task automatic t_latch();
    for (int i = 0; i < 6; i++) begin
      latch_cell_set = LS[i];
      latch_cell_clr = LC[i];
      cyc(3);
      check(q[QL], LE[i]);
    end
    $display("latch test done");
  endtask

  task automatic t_tog();
    for (int i = 0; i < 3; i++) begin
      tog_trg = 1'b1;
      cyc(3);
      check(q[QT], (i % 2) == 0);
      tog_trg = 1'b0;
      cyc(2);
    end
    tog_trg = 1'b1;
    tog_clr = 1'b1;
    cyc(3);
    check(q[QT], 1'b0);
    tog_clr = 1'b0;
    tog_trg = 1'b0;
    cyc(3);
    check(q[QT], 1'b0);
    $display("toggle test done");
  endtask

  task automatic t_pls();
    pls_trg = 1'b1;
    cyc(2);
    check(q[QP], 1'b1);
    cyc(10);
    check(q[QP], 1'b1);
    wait_q(QP, 1'b0, 14);
    pls_trg = 1'b0;
    cyc(2);
    pls_trg = 1'b1;
    cyc(5);
    check(q[QP], 1'b1);
    pls_trg = 1'b0;
    cyc(2);
    check(q[QP], 1'b0);
    $display("pulse test done");
  endtask

  task automatic t_power();
    for (int r = 1; r >= 0; r--) begin
      latch_cell_retain = r[0];
      tog_retain = r[0];
      latch_cell_set = 1'b1;
      tog_trg = 1'b1;
      rto_trg = 1'b1;
      cyc(3);
      latch_cell_set = 1'b0;
      tog_trg = 1'b0;
      cyc(10);
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      cyc(3);
      check(q[QL], r[0]);
      check(q[QT], r[0]);
      cyc(25);
      check(q[QR], 1'b0);
      rto_trg = 1'b0;
      tog_clr = 1'b1;
      latch_cell_clr = 1'b1;
      cyc(2);
      tog_clr = 1'b0;
      latch_cell_clr = 1'b0;
    end
    $display("power restore test done");
  endtask

  initial begin
    {rst, cold_rst, ood_trg, rto_trg, rto_clr, tog_trg, tog_clr, pls_trg} = 8'hC0;
    {latch_cell_set, latch_cell_clr, latch_cell_retain, tog_retain} = 4'h0;
    cyc(3);
    rst = 1'b0;
    cold_rst = 1'b0;
    cyc(3);
    t_ood();
    t_rto();
    t_latch();
    t_tog();
    t_pls();
    t_power();
    test_done();
  end

  // the tests take well under 1500 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    $display("wrong value at %0t: run timed out", $time);
    test_done();
  end
endmodule
`default_nettype wire
